// >>> ucx_pkg.sv
// Shared types and constants for the convolutional coder and bit interleaver
package ucx_pkg;

   // Kind of each incoming bit; tail kinds are forced to unscrambled zero
   typedef enum logic [2:0] {
      K_HDR      = 3'b000,
      K_HDR_TAIL = 3'b001,
      K_RS_TAIL  = 3'b010,
      K_PAY      = 3'b011,
      K_PAY_TAIL = 3'b100,
      K_PAD      = 3'b101
   } ucx_kind_t;

   // Data rate selector, lowest to highest
   typedef enum logic [2:0] {
      R53  = 3'b000,
      R80  = 3'b001,
      R107 = 3'b010,
      R160 = 3'b011,
      R200 = 3'b100,
      R320 = 3'b101,
      R400 = 3'b110,
      R480 = 3'b111
   } ucx_rate_t;

   // Code rate of the payload
   typedef enum logic [1:0] {
      CR_13 = 2'b00,
      CR_12 = 2'b01,
      CR_58 = 2'b10,
      CR_34 = 2'b11
   } ucx_crate_t;

   // Controller states
   typedef enum logic [1:0] {
      ST_FILL  = 2'b00,
      ST_CODE  = 2'b01,
      ST_DRAIN = 2'b10
   } ucx_state_t;

   // One upstream beat
   typedef struct packed {
      logic      data;
      ucx_kind_t kind;
      logic      first;
      ucx_rate_t rate;
   } ucx_beat_t;

   // Interleaver parameter set; span_mult is six over the spreading factor
   typedef struct packed {
      logic [7:0] coded_bits_per_symbol;
      logic [7:0] tone_block;
      logic [7:0] cyclic_shift;
      logic [2:0] span_mult;
   } ucx_ilv_t;

   localparam ucx_ilv_t ILV_SHORT = '{8'h64, 8'h0A, 8'h21, 3'h3};
   localparam ucx_ilv_t ILV_MID   = '{8'hC8, 8'h14, 8'h42, 3'h3};
   localparam ucx_ilv_t ILV_FULL  = '{8'hC8, 8'h14, 8'h21, 3'h6};

   // Generator polynomials, input bit in the MSB
   localparam logic [6:0] GEN_A = 7'h5B;
   localparam logic [6:0] GEN_B = 7'h75;
   localparam logic [6:0] GEN_C = 7'h79;

   // Keep masks, bit 3*n+phase, and their periods in input bits
   localparam logic [14:0] PUNC_12 = 15'h0003;
   localparam logic [14:0] PUNC_58 = 15'h32CB;
   localparam logic [14:0] PUNC_34 = 15'h004B;
   localparam logic [2:0]  PER_12  = 3'h1;
   localparam logic [2:0]  PER_58  = 3'h5;
   localparam logic [2:0]  PER_34  = 3'h3;

   // Buffer sizing and table constants
   localparam int          BUF_BITS   = 1200;
   localparam logic [10:0] SYMS_SPAN  = 11'h006;
   localparam logic [7:0]  TONE_ROWS  = 8'h0A;
   localparam logic [2:0]  LAST_SYM   = 3'h5;

   function automatic ucx_ilv_t ucx_ilv_of(input ucx_rate_t r);
      unique case (r)
         R53, R80:        return ILV_SHORT;
         R107, R160, R200: return ILV_MID;
         R320, R400, R480: return ILV_FULL;
      endcase
   endfunction

   function automatic ucx_crate_t ucx_crate_of(input ucx_rate_t r);
      unique case (r)
         R53, R107:        return CR_13;
         R80, R160, R320:  return CR_12;
         R200, R400:       return CR_58;
         R480:             return CR_34;
      endcase
   endfunction

endpackage

// >>> ucx_conv_ilv.sv
// Tail insertion, K=7 convolutional coder, puncturing and bit interleaver
//
// Overview of operation
// - Six zero tail bits after header and check sequence, flushing the coder.
// - Four unscrambled zero tail bits follow the parity field.
// - Tail after frame check sequence replaced by six unscrambled zeros.
// - Rate one-third coder, constraint seven, generators 133, 165, 171 octal.
// - Coded outputs leave in order A, then B, then C.
// - Higher rates drop coded bits by pattern, filled left to right.
// - Final partial pattern block is punctured where the coded bits end.
// - Whole header coded at one-third, starting from zero state.
// - Coder cleared to zero before the payload begins.
// - Payload coded at the rate belonging to its data rate.
// - Receiver puts neutral metric at punctured positions; decoder choice free.
// - Three interleave stages: six-symbol, tone, then cyclic shift.
// - Low rates: spreading two, 100 bits, tone block 10, shift 33.
// - Mid rates 2/200/20/66; top rates 1/200/20/33.
// - Symbol stage reads floor(i/N) + (6/spread)*(i mod N).
// - Tone stage reads floor(j/block) + 10*(j mod block).
// - Cyclic stage shifts symbol m by m times the shift amount.
`timescale 1ns/1ps

module ucx_conv_ilv (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   // Upstream bit stream
   input  wire ucx_pkg::ucx_beat_t in_beat,
   input  wire logic              in_valid,
   output logic                   in_ready,
   input  wire logic              blk_flush,
   // Downstream interleaved bits
   output logic                   out_valid,
   input  wire logic              out_ready,
   output logic                   out_bit
);

   ucx_pkg::ucx_state_t state, next_state;
   ucx_pkg::ucx_ilv_t   ilv, next_ilv;
   ucx_pkg::ucx_rate_t  rate, next_rate;
   logic        pay, next_pay;
   logic        cur, next_cur;
   logic [5:0]  sr, next_sr;
   logic [1:0]  phase, next_phase;
   logic [2:0]  pos, next_pos;
   logic        resume, next_resume;
   logic [10:0] wr_cnt, next_wr_cnt;
   logic [2:0]  m, next_m;
   logic [7:0]  k, next_k;
   logic [7:0]  c, next_c;
   logic [7:0]  c0, next_c0;
   logic        next_out_valid;
   logic        next_out_bit;

   logic        buf_mem [0:ucx_pkg::BUF_BITS-1];
   logic [8:0]  c0_sum;
   logic        we;
   logic        coded;
   logic        keep;
   logic [10:0] n6;
   logic [3:0]  pidx;
   logic [14:0] mask;
   logic [2:0]  period;
   logic [7:0]  q;
   logic [7:0]  r;
   logic [7:0]  sidx;
   logic [10:0] rd_addr;
   logic        rd_go;
   logic        last_rd;
   logic        take;
   logic        is_tail;
   ucx_pkg::ucx_crate_t crate;

   // Datapath helpers: coder output, keep decision, interleaver address
   always_comb begin
      n6     = 11'(ilv.coded_bits_per_symbol) * ucx_pkg::SYMS_SPAN;
      // Nine bits, as start plus 66 can pass 255 for 200-bit symbols
      c0_sum = {1'b0, c0} + {1'b0, ilv.cyclic_shift};
      crate  = ucx_pkg::ucx_crate_of(rate);
      unique case (phase)
         2'b00:   coded = ^({cur, sr} & ucx_pkg::GEN_A);
         2'b01:   coded = ^({cur, sr} & ucx_pkg::GEN_B);
         default: coded = ^({cur, sr} & ucx_pkg::GEN_C);
      endcase
      pidx = 4'({1'b0, pos} * 4'h3) + 4'(phase);
      unique case (crate)
         ucx_pkg::CR_12: begin
            mask   = ucx_pkg::PUNC_12;
            period = ucx_pkg::PER_12;
         end
         ucx_pkg::CR_58: begin
            mask   = ucx_pkg::PUNC_58;
            period = ucx_pkg::PER_58;
         end
         ucx_pkg::CR_34: begin
            mask   = ucx_pkg::PUNC_34;
            period = ucx_pkg::PER_34;
         end
         default: begin
            mask   = 15'h7FFF;
            period = ucx_pkg::PER_12;
         end
      endcase
      // Header is never punctured
      keep = !pay || mask[pidx];
      // Tone stage: row/column split of the cyclic position
      if (ilv.tone_block == ucx_pkg::TONE_ROWS) begin
         q = c / 8'h0A;
         r = c % 8'h0A;
      end else begin
         q = c / 8'h14;
         r = c % 8'h14;
      end
      sidx    = 8'(q + ucx_pkg::TONE_ROWS * r);
      // Symbol stage; q+10r stays below one symbol so floor part is m
      rd_addr = 11'(m) + 11'(ilv.span_mult) * 11'(sidx);
      rd_go   = (state == ucx_pkg::ST_DRAIN) && (!out_valid || out_ready);
      last_rd = (m == ucx_pkg::LAST_SYM) &&
                (k == ilv.coded_bits_per_symbol - 8'h01);
      is_tail = (in_beat.kind == ucx_pkg::K_HDR_TAIL) ||
                (in_beat.kind == ucx_pkg::K_RS_TAIL) ||
                (in_beat.kind == ucx_pkg::K_PAY_TAIL);
      // A first bit waits until any earlier partial block has drained
      in_ready = (state == ucx_pkg::ST_FILL) &&
                 !(in_beat.first && wr_cnt != 11'h000) &&
                 !(blk_flush && wr_cnt != 11'h000);
      take = in_valid && in_ready;
      we   = (state == ucx_pkg::ST_CODE) && keep;
   end

   // Next-state logic for control, coder and drain counters
   always_comb begin
      next_state     = state;
      next_ilv       = ilv;
      next_rate      = rate;
      next_pay       = pay;
      next_cur       = cur;
      next_sr        = sr;
      next_phase     = phase;
      next_pos       = pos;
      next_resume    = resume;
      next_wr_cnt    = wr_cnt;
      next_m         = m;
      next_k         = k;
      next_c         = c;
      next_c0        = c0;
      next_out_valid = out_valid && !out_ready;
      next_out_bit   = out_bit;
      unique case (state)
         ucx_pkg::ST_FILL: begin
            if (wr_cnt != 11'h000 &&
                (blk_flush || (in_valid && in_beat.first))) begin
               // Partial block: unwritten positions read as zero
               next_state  = ucx_pkg::ST_DRAIN;
               next_resume = 1'b0;
            end else if (take) begin
               // Tails go in as clean zeros, ignoring scrambled data
               next_cur   = is_tail ? 1'b0 : in_beat.data;
               next_phase = 2'b00;
               next_state = ucx_pkg::ST_CODE;
               if (in_beat.first) begin
                  next_sr  = 6'h00;
                  next_pos = 3'h0;
                  if (in_beat.kind == ucx_pkg::K_HDR) begin
                     next_pay = 1'b0;
                     next_ilv = ucx_pkg::ILV_SHORT;
                  end else begin
                     next_pay  = 1'b1;
                     next_rate = in_beat.rate;
                     next_ilv  = ucx_pkg::ucx_ilv_of(in_beat.rate);
                  end
               end
            end
         end
         ucx_pkg::ST_CODE: begin
            if (we) begin
               next_wr_cnt = wr_cnt + 11'h001;
            end
            if (phase == 2'b10) begin
               next_phase = 2'b00;
               next_sr    = {cur, sr[5:1]};
               next_pos   = (pos == period - 3'h1) ? 3'h0 : pos + 3'h1;
            end else begin
               next_phase = phase + 2'b01;
            end
            // Stops mid-bit if the block fills; resumes after draining
            if (we && next_wr_cnt == n6) begin
               next_state  = ucx_pkg::ST_DRAIN;
               next_resume = (phase != 2'b10);
            end else if (phase == 2'b10) begin
               next_state = ucx_pkg::ST_FILL;
            end
         end
         ucx_pkg::ST_DRAIN: begin
            if (rd_go) begin
               next_out_valid = 1'b1;
               next_out_bit   = (rd_addr < wr_cnt) ?
                                buf_mem[rd_addr] : 1'b0;
               if (k == ilv.coded_bits_per_symbol - 8'h01) begin
                  next_k = 8'h00;
                  next_m = m + 3'h1;
                  // Next symbol starts further round by one shift
                  next_c0 = (c0_sum >= {1'b0, ilv.coded_bits_per_symbol}) ?
                            8'(c0_sum - {1'b0, ilv.coded_bits_per_symbol}) :
                            8'(c0_sum);
                  next_c = next_c0;
               end else begin
                  next_k = k + 8'h01;
                  next_c = (c == ilv.coded_bits_per_symbol - 8'h01) ?
                           8'h00 : c + 8'h01;
               end
               if (last_rd) begin
                  next_wr_cnt = 11'h000;
                  next_m      = 3'h0;
                  next_k      = 8'h00;
                  next_c      = 8'h00;
                  next_c0     = 8'h00;
                  next_state  = resume ? ucx_pkg::ST_CODE :
                                         ucx_pkg::ST_FILL;
               end
            end
         end
         default: next_state = ucx_pkg::ST_FILL;
      endcase
   end

   // Control registers
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state     <= ucx_pkg::ST_FILL;
         ilv       <= ucx_pkg::ILV_SHORT;
         rate      <= ucx_pkg::R53;
         pay       <= 1'b0;
         cur       <= 1'b0;
         sr        <= 6'h00;
         phase     <= 2'b00;
         pos       <= 3'h0;
         resume    <= 1'b0;
         wr_cnt    <= 11'h000;
         m         <= 3'h0;
         k         <= 8'h00;
         c         <= 8'h00;
         c0        <= 8'h00;
         out_valid <= 1'b0;
         out_bit   <= 1'b0;
      end else begin
         state     <= next_state;
         ilv       <= next_ilv;
         rate      <= next_rate;
         pay       <= next_pay;
         cur       <= next_cur;
         sr        <= next_sr;
         phase     <= next_phase;
         pos       <= next_pos;
         resume    <= next_resume;
         wr_cnt    <= next_wr_cnt;
         m         <= next_m;
         k         <= next_k;
         c         <= next_c;
         c0        <= next_c0;
         out_valid <= next_out_valid;
         out_bit   <= next_out_bit;
      end
   end

   // Block store; contents need no reset since reads are masked by wr_cnt
   always_ff @(posedge clk_sys) begin
      if (we) begin
         buf_mem[wr_cnt] <= coded;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   AST_TAIL_ZERO:
      assert property (take && is_tail |=> cur == 1'b0 &&
                       state == ucx_pkg::ST_CODE)
      else $error("tail bit not forced to zero");

   AST_FIRST_CLEARS:
      assert property (take && in_beat.first |=> sr == 6'h00 &&
                       phase == 2'b00)
      else $error("coder not cleared at section start");

   AST_ABC_ORDER:
      assert property (state == ucx_pkg::ST_CODE && phase == 2'b00 &&
                       !(we && wr_cnt + 11'h001 == n6)
                       |=> phase == 2'b01 ##1 phase == 2'b10)
      else $error("coded outputs out of order");

   AST_HDR_UNPUNCT:
      assert property (state == ucx_pkg::ST_CODE && !pay |-> we)
      else $error("header bit dropped");

   AST_HALF_DROPS_C:
      assert property (state == ucx_pkg::ST_CODE && pay &&
                       crate == ucx_pkg::CR_12 && phase == 2'b10 |-> !we)
      else $error("rate one-half kept output C");

   AST_RATE_HOLD:
      assert property (!(take && in_beat.first) |=> $stable(rate))
      else $error("rate changed inside a section");

   AST_FULL_DRAINS:
      assert property (we && wr_cnt + 11'h001 == n6
                       |=> state == ucx_pkg::ST_DRAIN && wr_cnt == n6)
      else $error("full block did not start draining");

   AST_FIRST_ADDR:
      assert property (state == ucx_pkg::ST_DRAIN && m == 3'h0 &&
                       k == 8'h00 |-> rd_addr == 11'h000)
      else $error("first interleaved read not from index zero");

   AST_CYC_STEP:
      assert property (rd_go && !last_rd &&
                       k == ilv.coded_bits_per_symbol - 8'h01
                       |=> c == c0 && c0 < ilv.coded_bits_per_symbol &&
                           k == 8'h00)
      else $error("cyclic shift start wrong at symbol change");

   AST_OUT_HOLD:
      assert property (out_valid && !out_ready |=> out_valid &&
                       $stable(out_bit))
      else $error("output changed while stalled");

   AST_BLOCK_BOUND:
      assert property (wr_cnt <= n6)
      else $error("block store written past its size");

   AST_SHIFT_WRAP:
      assert property (rd_go && !last_rd &&
                       k == ilv.coded_bits_per_symbol - 8'h01
                       |=> {1'b0, c0} == ({1'b0, $past(c0)} +
                           {1'b0, ilv.cyclic_shift}) %
                           {1'b0, ilv.coded_bits_per_symbol})
      else $error("cyclic start not advanced modulo symbol size");

endmodule

// >>> ucx_sink.sv
// Downstream mapper stand-in that collects interleaved bits
`timescale 1ns/1ps

module ucx_sink (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rstn,
   // Bit stream from the coder
   input  wire logic out_valid,
   input  wire logic out_bit,
   output logic      out_ready,
   // Bench control
   input  wire logic slow,
   input  wire logic clr
);
   logic       mem [0:4095];
   int         cnt;
   logic [1:0] ph;

   // Slow mode stalls half the time so held outputs get exercised
   always_ff @(posedge clk_sys) begin
      if (!rstn || clr) begin
         cnt       <= 0;
         ph        <= 2'h0;
         out_ready <= 1'h0;
      end else begin
         ph        <= ph + 2'h1;
         out_ready <= !slow || ph[1];
         if (out_valid && out_ready) begin
            mem[cnt] <= out_bit;
            cnt      <= cnt + 1;
         end
      end
   end
endmodule

// >>> ucx_conv_ilv_tb.sv
// Self-checking bench for the coder and interleaver
`timescale 1ns/1ps

module ucx_conv_ilv_tb;
   logic               clk_sys = 1'h0;
   logic               rstn = 1'h0;
   ucx_pkg::ucx_beat_t in_beat = '0;
   logic               in_valid = 1'h0;
   logic               in_ready;
   logic               blk_flush = 1'h0;
   logic               out_valid;
   logic               out_ready;
   logic               out_bit;
   logic               slow = 1'h0;
   logic               clr = 1'h0;
   int                 mismatches = 0;
   int                 n_compared = 0;
   int                 cyc_cnt = 0;
   // Reference model state
   logic [5:0]         st;
   int                 ph, nb, tbs, cyc, spn;
   ucx_pkg::ucx_crate_t cr;
   logic               cq[$];
   logic               eq[$];

   ucx_conv_ilv dut (.clk_sys(clk_sys), .rstn(rstn), .in_beat(in_beat),
      .in_valid(in_valid), .in_ready(in_ready), .blk_flush(blk_flush),
      .out_valid(out_valid), .out_ready(out_ready), .out_bit(out_bit));
   ucx_sink u_sink (.clk_sys(clk_sys), .rstn(rstn), .out_valid(out_valid),
      .out_bit(out_bit), .out_ready(out_ready), .slow(slow), .clr(clr));

   // Clock and hang guard
   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc_cnt++;
      if (cyc_cnt >= 60000) begin
         mismatches++;
         $display("Error %0t: cycle limit reached", $time);
         give_verdict();
      end
   end

   task automatic cmp_bit(input logic g, input logic e, input string m);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("Error %0t: %s got %b exp %b", $time, m, g, e);
      end
   endtask

   // Parameters per section; r below zero means header
   task automatic set_rate(input int r);
      nb  = (r < 2) ? 100 : 200;
      tbs = nb / 10;
      cyc = (r >= 2 && r < 5) ? 66 : 33;
      spn = (r < 5) ? 3 : 6;
      cr  = (r < 0 || r == 0 || r == 2) ? ucx_pkg::CR_13 :
            (r == 4 || r == 6) ? ucx_pkg::CR_58 :
            (r == 7) ? ucx_pkg::CR_34 : ucx_pkg::CR_12;
      st  = 6'h00;
      ph  = 0;
   endtask

   // Zero-pad the block, then apply the three stages
   task automatic flush_blk();
      int n, m, t, k;
      if (cq.size() == 0) return;
      n = 6 * nb;
      while (cq.size() < n) cq.push_back(1'h0);
      for (int i = 0; i < n; i++) begin
         m = i / nb;
         t = m * nb + (i + m * cyc) % nb;
         k = m * nb + (t % nb) / tbs + 10 * ((t % nb) % tbs);
         eq.push_back(cq[k / nb + spn * (k % nb)]);
      end
      cq.delete();
   endtask

   // One input bit through coder and keep mask, A then B then C
   task automatic enc(input logic d);
      logic [6:0]  r;
      logic [2:0]  o;
      logic [14:0] msk;
      int          per;
      r = {d, st};
      st = r[6:1];
      o = {^(r & 7'h79), ^(r & 7'h75), ^(r & 7'h5b)};
      case (cr)
         ucx_pkg::CR_12: begin
            msk = ucx_pkg::PUNC_12;
            per = 1;
         end
         ucx_pkg::CR_58: begin
            msk = ucx_pkg::PUNC_58;
            per = 5;
         end
         ucx_pkg::CR_34: begin
            msk = ucx_pkg::PUNC_34;
            per = 3;
         end
         default: begin
            msk = 15'h7fff;
            per = 1;
         end
      endcase
      for (int k = 0; k < 3; k++) begin
         if (msk[3 * ph + k]) begin
            cq.push_back(o[k]);
            if (cq.size() == 6 * nb) flush_blk();
         end
      end
      ph = (ph + 1) % per;
   endtask

   // Offer one beat at a falling edge and wait until it is taken
   task automatic put(input logic d, input ucx_pkg::ucx_kind_t kd,
                      input logic f, input int r);
      int         w;
      logic [2:0] rf;
      if (f) begin
         flush_blk();
         set_rate(kd == ucx_pkg::K_HDR ? -1 : r);
      end
      // Only tail kinds are forced to zero; pad bits pass as given
      enc((kd == ucx_pkg::K_HDR_TAIL || kd == ucx_pkg::K_RS_TAIL ||
           kd == ucx_pkg::K_PAY_TAIL) ? 1'h0 : d);
      rf = f ? r[2:0] : 3'(7 - r);
      in_beat = '{d, kd, f, ucx_pkg::ucx_rate_t'(rf)};
      in_valid = 1'h1;
      w = 0;
      // Let ready settle on the new beat before looking at it
      #1;
      while (in_ready !== 1'h1 && w < 5000) begin
         @(negedge clk_sys);
         w++;
      end
      if (w >= 5000) begin
         mismatches++;
         $display("Error %0t: beat never accepted", $time);
      end
      @(negedge clk_sys);
   endtask

   // Flush the tail block and compare every collected bit
   task automatic done_stream();
      int w;
      flush_blk();
      in_valid = 1'h0;
      blk_flush = 1'h1;
      w = 0;
      while (u_sink.cnt < eq.size() && w < 8000) begin
         @(negedge clk_sys);
         w++;
      end
      blk_flush = 1'h0;
      repeat (10) @(negedge clk_sys);
      cmp_bit(1'(u_sink.cnt == eq.size()), 1'h1, "bit count");
      for (int k = 0; k < eq.size(); k++)
         cmp_bit(u_sink.mem[k], eq[k], "interleaved bit");
      eq.delete();
      clr = 1'h1;
      @(negedge clk_sys);
      clr = 1'h0;
   endtask

   task automatic t_reset();
      cmp_bit(in_ready, 1'h1, "ready after reset");
      cmp_bit(out_valid, 1'h0, "valid after reset");
      cmp_bit(out_bit, 1'h0, "bit after reset");
   endtask

   // Full header block with tails carrying ones that must code as zero
   task automatic t_header_full();
      for (int i = 0; i < 190; i++)
         put((i % 3 == 0) ^ (i % 7 == 1), ucx_pkg::K_HDR, i == 0, 0);
      for (int i = 0; i < 6; i++) put(1'h1, ucx_pkg::K_HDR_TAIL, 1'h0, 0);
      for (int i = 0; i < 4; i++) put(1'h1, ucx_pkg::K_RS_TAIL, 1'h0, 0);
      done_stream();
   endtask

   // Header left in a nonzero state, then a payload at the top rate
   task automatic t_hdr_then_pay();
      slow = 1'h1;
      for (int i = 0; i < 20; i++) put(1'h1, ucx_pkg::K_HDR, i == 0, 0);
      for (int i = 0; i < 50; i++)
         put(1'(i % 2), i >= 44 ? ucx_pkg::K_PAY_TAIL : ucx_pkg::K_PAY,
             i == 0, 7);
      done_stream();
   endtask

   // Padded payload fills one block exactly; last kept bit is a B output
   task automatic t_padded();
      slow = 1'h0;
      for (int i = 0; i < 300; i++)
         put(1'((i % 4) == 2), i >= 276 ? ucx_pkg::K_PAD :
             i >= 270 ? ucx_pkg::K_PAY_TAIL : ucx_pkg::K_PAY, i == 0, 1);
      done_stream();
   endtask

   // Every rate code, 41 bits so the last 5/8 and 3/4 period is partial
   task automatic t_rates();
      for (int r = 0; r < 8; r++) begin
         slow = 1'(r % 2);
         for (int i = 0; i < 41; i++)
            put((i % 3 == 1) ^ (i % 5 == 0),
                i >= 35 ? ucx_pkg::K_PAY_TAIL : ucx_pkg::K_PAY, i == 0, r);
         done_stream();
      end
   endtask

   task automatic give_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (12) @(negedge clk_sys);
      rstn = 1'h1;
      t_reset();
      t_header_full();
      t_hdr_then_pay();
      t_padded();
      t_rates();
      give_verdict();
   end
endmodule
